// file: fsp_pkg.sv
// constants, types and carriers for the flash self-program command sequencer
// Behaviour
// - flash address comes from pointer low, high and extension bytes.
// - pointer bits word_index_top_bit down to 1 index the word in a page.
// - higher pointer bits give the page; page and word form the word address.
// - on flash reads pointer bit 0 picks low byte (0) or high byte (1).
// - address is latched when an operation starts; pointer may then change.
// - 7-bit command code; 0x00 makes a load a plain flash byte read.
// - execute bit triggers action commands; load and store trigger the rest.
// - 0x23 store puts the data pair into the page buffer, no busy.
// - 0x26 with execute bit erases the page buffer, protected, no halt.
// - busy stays set while the page buffer erase runs, then clears.
// - 0x2B, 0x2E, 0x2F store-triggered, protected, busy; halt only in boot.
// - 0x22, 0x24, 0x25 store-triggered, protected, busy, no halt.
// - 0x20 whole application erase: protected, busy, halts the CPU.
// - 0x2A, 0x2C, 0x2D boot page commands: protected, busy, halt the CPU.
// - 0x18 and 0x1A signature row erase/write: protected, busy, halt, no pointer.
// - 0x01 and 0x02 load returns a signature or calibration row byte.
// - read byte is delivered within the load access itself.
// - protected triggers need the unlock window, except from an external programmer.
// - unloaded page buffer words commit as all ones.
// - flash busy flag held during application and boot section operations; application reads blocked.
// - section page command aborts when the page is outside its section.
package fsp_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_CONTROL_REGISTER_A  = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_PTR    = 8'h0C;
  localparam logic [7:0] OFF_DATA   = 8'h10;
  localparam logic [7:0] OFF_UNLOCK = 8'h14;
  localparam logic [7:0] OFF_STORE  = 8'h18;
  localparam logic [7:0] OFF_LOAD   = 8'h1C;
  // field positions
  localparam int CONTROL_REGISTER_A_EXEC  = 0;
  localparam int STAT_BUSY   = 1 - 1;
  localparam int STAT_FLASH_SECTION_BUSY_FLAG  = 1;
  localparam int STAT_HALT   = 2;
  localparam int PTR_HI_BYTE = 0;
  // command codes
  localparam logic [6:0] CMD_NOP     = 7'h00;
  localparam logic [6:0] CMD_RDSIG   = 7'h01;
  localparam logic [6:0] CMD_RDCAL   = 7'h02;
  localparam logic [6:0] CMD_ERSIG   = 7'h18;
  localparam logic [6:0] CMD_WRSIG   = 7'h1A;
  localparam logic [6:0] CMD_ERAPP   = 7'h20;
  localparam logic [6:0] CMD_ERAPG   = 7'h22;
  localparam logic [6:0] CMD_LDBUF   = 7'h23;
  localparam logic [6:0] CMD_WRAPG   = 7'h24;
  localparam logic [6:0] CMD_EWAPG   = 7'h25;
  localparam logic [6:0] CMD_ERBUF   = 7'h26;
  localparam logic [6:0] CMD_ERBPG   = 7'h2A;
  localparam logic [6:0] CMD_ERPG    = 7'h2B;
  localparam logic [6:0] CMD_WRBPG   = 7'h2C;
  localparam logic [6:0] CMD_EWBPG   = 7'h2D;
  localparam logic [6:0] CMD_WRPG    = 7'h2E;
  localparam logic [6:0] CMD_EWPG    = 7'h2F;
  // values
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0]  UNLOCK_KEY  = 8'h9D;
  // unlock window: longest time, rounded down to whole cycles
  localparam int CLK_NS     = 50;
  localparam int UNLOCK_NS  = 200;
  localparam int UNLOCK_CYC = UNLOCK_NS / CLK_NS;
  typedef enum logic [1:0] {
    FSP_OP_ERASE = 2'b00,
    FSP_OP_WRITE = 2'b01,
    FSP_OP_ERWR  = 2'b10,
    FSP_OP_ERAPP = 2'b11
  } fsp_op_t;
  typedef enum logic [1:0] {
    FSP_TGT_FLASH = 2'b00,
    FSP_TGT_SIG   = 2'b01,
    FSP_TGT_CAL   = 2'b10
  } fsp_tgt_t;
  typedef enum logic [1:0] {
    FSP_ST_IDLE  = 2'b00,
    FSP_ST_BCLR  = 2'b01,
    FSP_ST_FLASH = 2'b10
  } fsp_state_t;
  typedef enum logic [1:0] {
    FSP_CHK_NONE = 2'b00,
    FSP_CHK_APP  = 2'b01,
    FSP_CHK_BOOT = 2'b10
  } fsp_chk_t;
  // request handed to the flash macro
  typedef struct packed {
    fsp_op_t     op;
    fsp_tgt_t    tgt;
    logic [15:0] page;
  } fsp_freq_t;
endpackage : fsp_pkg

// file: fsp_ctrl.sv
// flash self-program command decoder and sequencer with apb register slave
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/100ps
module fsp_ctrl #(
  parameter int WORD_TOP  = 7,
  parameter int PAGE_TOP  = 17,
  parameter int BOOT_PAGE = 960
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                ext_prog_pin,
  output logic                     fl_req,
  output fsp_pkg::fsp_freq_t       fl_cmd,
  input  wire logic                fl_done,
  input  wire logic [WORD_TOP-1:0] fl_bidx,
  output logic      [15:0]         fl_bdata,
  output logic      [22:0]         fl_raddr,
  output fsp_pkg::fsp_tgt_t        fl_rsel,
  input  wire logic [15:0]         fl_rdata,
  output logic                     nvm_busy,
  output logic                     fl_busy,
  output logic                     cpu_halt
);
  localparam int DEPTH = 1 << WORD_TOP;

  logic [6:0]          cmd_reg;
  logic [23:0]         ptr_reg;
  logic [15:0]         data_reg;
  logic [2:0]          unl_reg;
  logic                xs1_reg, xs2_reg, xs3_reg, ext_reg;
  logic [15:0]         buf_mem [DEPTH];
  logic [DEPTH-1:0]    ld_reg;
  logic                rd_hi_reg, rd_app_reg;
  fsp_pkg::fsp_state_t state_reg;
  logic                acc, hold, unlocked, in_boot, sec_ok;
  logic                st_go, ex_go, fop_go, ldb_go, undef_go;
  logic [15:0]         cur_page;
  logic [WORD_TOP-1:0] cur_word;
  logic                dec_flash, dec_halt, dec_def;
  fsp_pkg::fsp_op_t    dec_op;
  fsp_pkg::fsp_tgt_t   dec_tgt;
  fsp_pkg::fsp_chk_t   dec_chk;
  logic [31:0]         rd_val;
  logic                rd_err;

  // pointer split into page number and word index
  assign cur_word = ptr_reg[WORD_TOP:1];
  assign cur_page = 16'(ptr_reg[PAGE_TOP:WORD_TOP+1]);
  assign in_boot  = cur_page >= 16'(BOOT_PAGE);
  assign unlocked = (unl_reg != 3'h0) || ext_reg;

  // application reads wait while the flash array is busy
  assign hold = psel && !pwrite && (paddr == fsp_pkg::OFF_LOAD) && fl_busy && rd_app_reg;
  assign acc  = psel && penable && pready;

  // triggers, taken at the edge that completes the bus write
  assign st_go = acc && pwrite && (paddr == fsp_pkg::OFF_STORE);
  assign ex_go = acc && pwrite && (paddr == fsp_pkg::OFF_CONTROL_REGISTER_A) && pwdata[fsp_pkg::CONTROL_REGISTER_A_EXEC]
                 && (cmd_reg == fsp_pkg::CMD_ERBUF) && unlocked
                 && (state_reg == fsp_pkg::FSP_ST_IDLE);
  assign ldb_go = st_go && (cmd_reg == fsp_pkg::CMD_LDBUF)
                  && (state_reg != fsp_pkg::FSP_ST_BCLR);
  assign sec_ok = (dec_chk == fsp_pkg::FSP_CHK_NONE)
                  || ((dec_chk == fsp_pkg::FSP_CHK_APP) && !in_boot)
                  || ((dec_chk == fsp_pkg::FSP_CHK_BOOT) && in_boot);
  assign fop_go = st_go && dec_flash && sec_ok && unlocked
                  && (state_reg == fsp_pkg::FSP_ST_IDLE);
  assign undef_go = st_go && !dec_def;

  // command decode: flash operation, target and section demanded
  always_comb
  begin
    dec_flash = 1'b1;
    dec_def   = 1'b1;
    dec_op    = fsp_pkg::FSP_OP_ERASE;
    dec_tgt   = fsp_pkg::FSP_TGT_FLASH;
    dec_chk   = fsp_pkg::FSP_CHK_NONE;
    case (cmd_reg)
      fsp_pkg::CMD_ERPG:  dec_op = fsp_pkg::FSP_OP_ERASE;
      fsp_pkg::CMD_WRPG:  dec_op = fsp_pkg::FSP_OP_WRITE;
      fsp_pkg::CMD_EWPG:  dec_op = fsp_pkg::FSP_OP_ERWR;
      fsp_pkg::CMD_ERAPP: dec_op = fsp_pkg::FSP_OP_ERAPP;
      fsp_pkg::CMD_ERAPG:
      begin
        dec_op  = fsp_pkg::FSP_OP_ERASE;
        dec_chk = fsp_pkg::FSP_CHK_APP;
      end
      fsp_pkg::CMD_WRAPG:
      begin
        dec_op  = fsp_pkg::FSP_OP_WRITE;
        dec_chk = fsp_pkg::FSP_CHK_APP;
      end
      fsp_pkg::CMD_EWAPG:
      begin
        dec_op  = fsp_pkg::FSP_OP_ERWR;
        dec_chk = fsp_pkg::FSP_CHK_APP;
      end
      fsp_pkg::CMD_ERBPG:
      begin
        dec_op  = fsp_pkg::FSP_OP_ERASE;
        dec_chk = fsp_pkg::FSP_CHK_BOOT;
      end
      fsp_pkg::CMD_WRBPG:
      begin
        dec_op  = fsp_pkg::FSP_OP_WRITE;
        dec_chk = fsp_pkg::FSP_CHK_BOOT;
      end
      fsp_pkg::CMD_EWBPG:
      begin
        dec_op  = fsp_pkg::FSP_OP_ERWR;
        dec_chk = fsp_pkg::FSP_CHK_BOOT;
      end
      fsp_pkg::CMD_ERSIG:
      begin
        dec_op  = fsp_pkg::FSP_OP_ERASE;
        dec_tgt = fsp_pkg::FSP_TGT_SIG;
      end
      fsp_pkg::CMD_WRSIG:
      begin
        dec_op  = fsp_pkg::FSP_OP_WRITE;
        dec_tgt = fsp_pkg::FSP_TGT_SIG;
      end
      fsp_pkg::CMD_NOP, fsp_pkg::CMD_RDSIG, fsp_pkg::CMD_RDCAL,
      fsp_pkg::CMD_LDBUF, fsp_pkg::CMD_ERBUF: dec_flash = 1'b0;
      default:
      begin
        dec_flash = 1'b0;
        dec_def   = 1'b0;
      end
    endcase
  end

  // halt when the target cannot be read during programming
  assign dec_halt = (dec_tgt == fsp_pkg::FSP_TGT_SIG) || (dec_op == fsp_pkg::FSP_OP_ERAPP)
                    || in_boot;

  // software registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_reg  <= 7'h00;
      ptr_reg  <= 24'h000000;
      data_reg <= 16'h0000;
    end
    else if (acc && pwrite)
    begin
      if (paddr == fsp_pkg::OFF_CMD)
        cmd_reg <= pwdata[6:0];
      if (paddr == fsp_pkg::OFF_PTR)
        ptr_reg <= pwdata[23:0];
      if (paddr == fsp_pkg::OFF_DATA)
        data_reg <= pwdata[15:0];
    end
  end

  // unlock window opened by the key, counted down each cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      unl_reg <= 3'h0;
    else if (acc && pwrite && (paddr == fsp_pkg::OFF_UNLOCK)
             && (pwdata[7:0] == fsp_pkg::UNLOCK_KEY))
      unl_reg <= 3'(fsp_pkg::UNLOCK_CYC);
    else if (unl_reg != 3'h0)
      unl_reg <= unl_reg - 3'h1;
  end

  // external programmer strap: three flops, change taken when two agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xs1_reg <= 1'b0;
      xs2_reg <= 1'b0;
      xs3_reg <= 1'b0;
      ext_reg <= 1'b0;
    end
    else
    begin
      xs1_reg <= ext_prog_pin;
      xs2_reg <= xs1_reg;
      xs3_reg <= xs2_reg;
      if (xs2_reg == xs3_reg)
        ext_reg <= xs3_reg;
    end
  end

  // sequencer: buffer clear takes one cycle, flash ops wait for the macro
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= fsp_pkg::FSP_ST_IDLE;
    else
    begin
      unique case (state_reg)
        fsp_pkg::FSP_ST_IDLE:
        begin
          if (ex_go)
            state_reg <= fsp_pkg::FSP_ST_BCLR;
          else if (fop_go)
            state_reg <= fsp_pkg::FSP_ST_FLASH;
        end
        fsp_pkg::FSP_ST_BCLR:
          state_reg <= fsp_pkg::FSP_ST_IDLE;
        fsp_pkg::FSP_ST_FLASH:
        begin
          // signature row write empties the buffer afterwards
          if (fl_done && (fl_cmd.tgt == fsp_pkg::FSP_TGT_SIG)
              && (fl_cmd.op == fsp_pkg::FSP_OP_WRITE))
            state_reg <= fsp_pkg::FSP_ST_BCLR;
          else if (fl_done)
            state_reg <= fsp_pkg::FSP_ST_IDLE;
        end
        default:
          state_reg <= fsp_pkg::FSP_ST_IDLE;
      endcase
    end
  end

  // status outputs follow the sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nvm_busy <= 1'b0;
      fl_busy  <= 1'b0;
      fl_req   <= 1'b0;
      cpu_halt <= 1'b0;
    end
    else if ((state_reg == fsp_pkg::FSP_ST_IDLE) && ex_go)
    begin
      nvm_busy <= 1'b1;
    end
    else if ((state_reg == fsp_pkg::FSP_ST_IDLE) && fop_go)
    begin
      nvm_busy <= 1'b1;
      fl_busy  <= (dec_tgt == fsp_pkg::FSP_TGT_FLASH);
      fl_req   <= 1'b1;
      cpu_halt <= dec_halt;
    end
    else if (state_reg == fsp_pkg::FSP_ST_BCLR)
    begin
      nvm_busy <= 1'b0;
    end
    else if ((state_reg == fsp_pkg::FSP_ST_FLASH) && fl_done)
    begin
      // buffer clear after a row write runs without halting
      nvm_busy <= (fl_cmd.tgt == fsp_pkg::FSP_TGT_SIG) && (fl_cmd.op == fsp_pkg::FSP_OP_WRITE);
      fl_busy  <= 1'b0;
      fl_req   <= 1'b0;
      cpu_halt <= 1'b0;
    end
  end

  // latched request: the pointer may move on once this is taken
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fl_cmd <= '{fsp_pkg::FSP_OP_ERASE, fsp_pkg::FSP_TGT_FLASH, 16'h0000};
    else if ((state_reg == fsp_pkg::FSP_ST_IDLE) && fop_go)
      fl_cmd <= '{dec_op, dec_tgt, cur_page};
  end

  // page buffer storage; loaded mask decides what commits
  always_ff @(posedge pclk)
  begin
    if (ldb_go)
      buf_mem[cur_word] <= data_reg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ld_reg <= '0;
    else if (state_reg == fsp_pkg::FSP_ST_BCLR)
      ld_reg <= '0;
    else if (ldb_go)
      ld_reg[cur_word] <= 1'b1;
  end

  // buffer word for the macro, unloaded words read as erased
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fl_bdata <= fsp_pkg::ERASED_WORD;
    else if (ld_reg[fl_bidx])
      fl_bdata <= buf_mem[fl_bidx];
    else
      fl_bdata <= fsp_pkg::ERASED_WORD;
  end

  // read address latched in the setup cycle of a load access
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fl_raddr   <= 23'h000000;
      fl_rsel    <= fsp_pkg::FSP_TGT_FLASH;
      rd_hi_reg  <= 1'b0;
      rd_app_reg <= 1'b0;
    end
    else if (psel && !penable && !pwrite && (paddr == fsp_pkg::OFF_LOAD))
    begin
      fl_raddr   <= ptr_reg[23:1];
      rd_hi_reg  <= ptr_reg[fsp_pkg::PTR_HI_BYTE];
      rd_app_reg <= (cmd_reg == fsp_pkg::CMD_NOP) && !in_boot;
      if (cmd_reg == fsp_pkg::CMD_RDSIG)
        fl_rsel <= fsp_pkg::FSP_TGT_SIG;
      else if (cmd_reg == fsp_pkg::CMD_RDCAL)
        fl_rsel <= fsp_pkg::FSP_TGT_CAL;
      else
        fl_rsel <= fsp_pkg::FSP_TGT_FLASH;
    end
  end

  // read mux; the load byte comes straight out of the access
  always_comb
  begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    case (paddr)
      fsp_pkg::OFF_CMD:    rd_val = 32'(cmd_reg);
      fsp_pkg::OFF_CONTROL_REGISTER_A:  rd_val = 32'h00000000;
      fsp_pkg::OFF_STATUS: rd_val = 32'({cpu_halt, fl_busy, nvm_busy});
      fsp_pkg::OFF_PTR:    rd_val = 32'(ptr_reg);
      fsp_pkg::OFF_DATA:   rd_val = 32'(data_reg);
      fsp_pkg::OFF_UNLOCK: rd_val = 32'(unl_reg != 3'h0);
      fsp_pkg::OFF_STORE:  rd_val = 32'h00000000;
      fsp_pkg::OFF_LOAD:
      begin
        if ((cmd_reg == fsp_pkg::CMD_NOP) || (cmd_reg == fsp_pkg::CMD_RDSIG)
            || (cmd_reg == fsp_pkg::CMD_RDCAL))
          rd_val = rd_hi_reg ? 32'(fl_rdata[15:8]) : 32'(fl_rdata[7:0]);
      end
      default: rd_err = 1'b1;
    endcase
  end

  // apb answer: one wait state, more while a blocked read waits
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
    else if (psel && penable && !pready && !hold)
    begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h00000000 : rd_val;
      pslverr <= rd_err;
    end
    else
    begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // checks next to the logic they guard
  property p_ldbuf_quiet;
    @(posedge pclk) disable iff (!presetn)
    ldb_go && !nvm_busy |=> !nvm_busy && !cpu_halt;
  endproperty
  a_ldbuf_quiet: assert property (p_ldbuf_quiet) else $error("buffer load set busy");

  property p_bclr_pulse;
    @(posedge pclk) disable iff (!presetn)
    ex_go |=> nvm_busy && !cpu_halt ##1 !nvm_busy && (ld_reg == '0);
  endproperty
  a_bclr_pulse: assert property (p_bclr_pulse) else $error("erase busy wrong");

  property p_prot_block;
    @(posedge pclk) disable iff (!presetn)
    st_go && dec_flash && !unlocked && !fl_req |=> !fl_req;
  endproperty
  a_prot_block: assert property (p_prot_block) else $error("locked store started op");

  property p_app_nohalt;
    @(posedge pclk) disable iff (!presetn)
    fop_go && (dec_chk == fsp_pkg::FSP_CHK_APP) |=> fl_req && !cpu_halt && nvm_busy;
  endproperty
  a_app_nohalt: assert property (p_app_nohalt) else $error("app page op halted");

  property p_boot_halt;
    @(posedge pclk) disable iff (!presetn)
    fop_go && ((dec_chk == fsp_pkg::FSP_CHK_BOOT) || dec_tgt == fsp_pkg::FSP_TGT_SIG)
    |=> cpu_halt && nvm_busy;
  endproperty
  a_boot_halt: assert property (p_boot_halt) else $error("boot or row not halted");

  property p_flash_section_busy_flag;
    @(posedge pclk) disable iff (!presetn)
    fl_req && (fl_cmd.tgt == fsp_pkg::FSP_TGT_FLASH) |-> fl_busy && nvm_busy;
  endproperty
  a_flash_section_busy_flag: assert property (p_flash_section_busy_flag) else $error("flash busy flag low");

  property p_latch;
    @(posedge pclk) disable iff (!presetn)
    fl_req ##1 fl_req |-> $stable(fl_cmd);
  endproperty
  a_latch: assert property (p_latch) else $error("request changed mid operation");

  property p_unloaded;
    @(posedge pclk) disable iff (!presetn)
    !ld_reg[fl_bidx] |=> fl_bdata == fsp_pkg::ERASED_WORD;
  endproperty
  a_unloaded: assert property (p_unloaded) else $error("unloaded word not erased");

  property p_undef;
    @(posedge pclk) disable iff (!presetn)
    undef_go && !nvm_busy |=> !nvm_busy && !fl_req && $stable(ld_reg);
  endproperty
  a_undef: assert property (p_undef) else $error("undefined command acted");

  property p_abort;
    @(posedge pclk) disable iff (!presetn)
    st_go && dec_flash && !sec_ok && !fl_req |=> !fl_req;
  endproperty
  a_abort: assert property (p_abort) else $error("out of section op started");
endmodule : fsp_ctrl

// file: fsp_flash_model.sv
// behavioural flash macro facing the sequencer: timed operations and buffer capture
`timescale 1ns/100ps
module fsp_flash_model #(
  parameter int WORD_TOP = 7
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                fl_req,
  input  wire logic [15:0]         fl_bdata,
  input  wire logic [22:0]         fl_raddr,
  input  wire logic [1:0]          fl_rsel,
  input  wire logic [7:0]          extra,
  output logic                     fl_done,
  output logic      [WORD_TOP-1:0] fl_bidx,
  output logic      [15:0]         fl_rdata
);
  localparam int WORDS = 1 << WORD_TOP;
  logic [15:0] mem [WORDS];
  logic [9:0]  cnt_reg;
  logic        fin_reg;
  // read data is a plain function of address and row so every byte is predictable
  assign fl_rdata = {~fl_raddr[7:0], fl_raddr[7:0] ^ {6'h00, fl_rsel}};
  assign fl_bidx  = cnt_reg[WORD_TOP-1:0];
  // walk the whole buffer, data for an index comes a cycle later; extra makes it slow
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_reg <= 10'h000;
      fin_reg <= 1'b0;
      fl_done <= 1'b0;
    end
    else
    begin
      fl_done <= 1'b0;
      if (!fl_req)
      begin
        cnt_reg <= 10'h000;
        fin_reg <= 1'b0;
      end
      else if (!fin_reg)
      begin
        cnt_reg <= cnt_reg + 10'h001;
        if (cnt_reg >= 1 && cnt_reg <= WORDS)
          mem[cnt_reg - 10'h001] <= fl_bdata;
        if (cnt_reg == WORDS + extra + 1)
        begin
          fl_done <= 1'b1;
          fin_reg <= 1'b1;
        end
      end
    end
  end
endmodule : fsp_flash_model

// file: fsp_ctrl_bench.sv
// self-checking bench for the flash self-program sequencer over apb
`timescale 1ns/100ps
module fsp_ctrl_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_prog_pin;
  logic fl_req, fl_done, nvm_busy, fl_busy, cpu_halt, rerr;
  logic [7:0]  paddr, extra;
  logic [31:0] pwdata, prdata, rdat;
  logic [6:0]  fl_bidx;
  logic [15:0] fl_bdata, fl_rdata;
  logic [22:0] fl_raddr;
  logic [19:0] row;
  fsp_pkg::fsp_freq_t fl_cmd;
  fsp_pkg::fsp_tgt_t  fl_rsel;
  int miscompares = 0;
  int total_checks = 0;
  // rows: command, boot page, trigger mode (0 none, 1 unlock, 2 external), {halt, flash_section_busy_flag, busy}
  logic [19:0] rows [16] = '{20'h22_0_1_3, 20'h25_0_1_3, 20'h22_1_1_0, 20'h2A_1_1_7,
    20'h2A_0_1_0, 20'h2C_1_1_7, 20'h2D_1_1_7, 20'h2B_0_1_3, 20'h2E_1_1_7, 20'h2F_0_1_3,
    20'h20_0_1_7, 20'h18_0_1_5, 20'h1A_0_1_5, 20'h24_0_0_0, 20'h24_0_2_3, 20'h7F_0_1_0};

  fsp_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_prog_pin(ext_prog_pin), .fl_req(fl_req), .fl_cmd(fl_cmd),
    .fl_done(fl_done), .fl_bidx(fl_bidx), .fl_bdata(fl_bdata), .fl_raddr(fl_raddr),
    .fl_rsel(fl_rsel), .fl_rdata(fl_rdata), .nvm_busy(nvm_busy), .fl_busy(fl_busy),
    .cpu_halt(cpu_halt));
  fsp_flash_model u_flash (.pclk(pclk), .presetn(presetn), .fl_req(fl_req),
    .fl_bdata(fl_bdata), .fl_raddr(fl_raddr), .fl_rsel(fl_rsel), .extra(extra),
    .fl_done(fl_done), .fl_bidx(fl_bidx), .fl_rdata(fl_rdata));

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      miscompares++;
    end
  endtask : chk

  // one transfer; the bus stays selected so a following setup may come at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 1000);
    rdat = prdata;
    rerr = pslverr;
    if (n >= 1000)
    begin
      $display("ERROR t=%0t bus access timed out", $time);
      miscompares++;
      test_done();
    end
  endtask : apb

  task automatic idle(input int n);
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic wait_idle();
    int n;
    n = 0;
    idle(1);
    while ((nvm_busy !== 1'b0 || fl_req !== 1'b0 || fl_busy !== 1'b0) && n < 1000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 1000)
    begin
      $display("ERROR t=%0t sequencer never went idle", $time);
      miscompares++;
      test_done();
    end
  endtask : wait_idle

  // unlock sits right before the trigger, well inside the short window
  task automatic run_op(input logic [6:0] c, input logic [31:0] p);
    apb(1'b1, fsp_pkg::OFF_CMD, {25'h0, c});
    apb(1'b1, fsp_pkg::OFF_PTR, p);
    apb(1'b1, fsp_pkg::OFF_UNLOCK, {24'h0, fsp_pkg::UNLOCK_KEY});
    apb(1'b1, fsp_pkg::OFF_STORE, 32'h0);
  endtask : run_op

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_prog_pin = 1'b0;
    extra = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, fsp_pkg::OFF_STATUS, 32'h0);
    chk(rdat, 32'h0, "status after reset");
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, rerr}, 32'h1, "unmapped offset");
    // plain flash, signature and calibration reads, both bytes, extension byte set
    for (int c = 0; c < 3; c++)
      for (int b = 0; b < 2; b++)
      begin
        apb(1'b1, fsp_pkg::OFF_CMD, 32'(c));
        apb(1'b1, fsp_pkg::OFF_PTR, 32'h01_0122 + 32'(b));
        apb(1'b0, fsp_pkg::OFF_PTR, 32'h0);
        chk(rdat, 32'h01_0122 + 32'(b), "pointer readback");
        apb(1'b0, fsp_pkg::OFF_LOAD, 32'h0);
        chk(rdat, b ? 32'h6E : 32'h91 ^ 32'(c), "load byte");
        chk({9'h0, fl_raddr}, 32'h8091, "read word address");
        chk({30'h0, nvm_busy, cpu_halt}, 32'h0, "read flags");
      end
    $display("test reads done");
    // every flash command, section check, protection and undefined code
    for (int i = 0; i < 16; i++)
    begin
      row = rows[i];
      extra <= 8'(i * 5);
      ext_prog_pin <= (row[7:4] == 4'h2);
      idle(6);
      apb(1'b1, fsp_pkg::OFF_CMD, {24'h0, row[19:12]});
      apb(1'b1, fsp_pkg::OFF_PTR, row[11:8] != 4'h0 ? 32'h3C000 : 32'h100);
      if (row[7:4] == 4'h1)
        apb(1'b1, fsp_pkg::OFF_UNLOCK, {24'h0, fsp_pkg::UNLOCK_KEY});
      apb(1'b1, fsp_pkg::OFF_STORE, 32'h0);
      idle(2);
      chk({28'h0, fl_req, cpu_halt, fl_busy, nvm_busy}, {28'h0, row[0], row[2:0]},
          "op flags");
      wait_idle();
    end
    ext_prog_pin <= 1'b0;
    $display("test commands done");
    // buffer load, latched address, stalled application read, unloaded words
    apb(1'b1, fsp_pkg::OFF_CMD, 32'(fsp_pkg::CMD_LDBUF));
    apb(1'b1, fsp_pkg::OFF_PTR, 32'h2);
    apb(1'b1, fsp_pkg::OFF_DATA, 32'h1234);
    apb(1'b1, fsp_pkg::OFF_STORE, 32'h0);
    idle(1);
    chk({31'h0, nvm_busy}, 32'h0, "buffer load busy");
    run_op(fsp_pkg::CMD_WRAPG, 32'h100);
    apb(1'b1, fsp_pkg::OFF_PTR, 32'h200);
    apb(1'b1, fsp_pkg::OFF_CMD, 32'h0);
    idle(2);
    chk({12'h000, fl_cmd}, {12'h000, fsp_pkg::FSP_OP_WRITE, fsp_pkg::FSP_TGT_FLASH, 16'h0001},
        "latched request");
    apb(1'b0, fsp_pkg::OFF_LOAD, 32'h0);
    chk({31'h0, fl_busy}, 32'h0, "read held during flash busy");
    wait_idle();
    chk({16'h0, u_flash.mem[1]}, 32'h1234, "loaded word");
    chk({16'h0, u_flash.mem[0]}, 32'hFFFF, "unloaded word");
    // buffer erase by execute bit, then commit shows erased words
    apb(1'b1, fsp_pkg::OFF_CMD, 32'(fsp_pkg::CMD_LDBUF));
    apb(1'b1, fsp_pkg::OFF_STORE, 32'h0);
    apb(1'b1, fsp_pkg::OFF_CMD, 32'(fsp_pkg::CMD_ERBUF));
    apb(1'b1, fsp_pkg::OFF_UNLOCK, {24'h0, fsp_pkg::UNLOCK_KEY});
    apb(1'b1, fsp_pkg::OFF_CONTROL_REGISTER_A, 32'h1);
    idle(1);
    chk({31'h0, nvm_busy}, 32'h1, "buffer erase busy");
    wait_idle();
    run_op(fsp_pkg::CMD_WRAPG, 32'h100);
    wait_idle();
    chk({16'h0, u_flash.mem[1]}, 32'hFFFF, "erased buffer word");
    $display("test buffer done");
    test_done();
  end
endmodule : fsp_ctrl_bench
